// ---- hw/rsf_pkg.sv ----
// Package: register map, field positions and constants of the return stack block
package rsf_pkg;
  localparam int          RSF_PC_W          = 21;
  localparam int          RSF_DEPTH         = 31;
  localparam logic [4:0]  RSF_SP_MAX        = 5'h1f;
  localparam logic [4:0]  RSF_SP_ZERO       = 5'h00;
  // Pointer register fields
  localparam int          RSF_FULL_BIT      = 7;
  localparam int          RSF_UNF_BIT       = 6;
  localparam logic [7:0]  RSF_PTR_RESET     = 8'h00;
  // Register byte addresses
  localparam logic [7:0]  RSF_ADDR_PTR      = 8'h00;
  localparam logic [7:0]  RSF_ADDR_CFG      = 8'h04;
  localparam logic [7:0]  RSF_ADDR_HOLD     = 8'h08;
  localparam logic [7:0]  RSF_ADDR_TABLE_BYTE_POINTER   = 8'h0c;
  localparam logic [7:0]  RSF_ADDR_TBLDAT   = 8'h10;
  localparam logic [7:0]  RSF_ADDR_IRQ_ST   = 8'h14;
  localparam logic [7:0]  RSF_ADDR_IRQ_EN   = 8'h18;
  localparam logic [7:0]  RSF_ADDR_IRQ_CLR  = 8'h1c;
  localparam logic [7:0]  RSF_ADDR_PC       = 8'h20;
  localparam logic [7:0]  RSF_ADDR_CORE     = 8'h24;
  // Configuration bit positions
  localparam int          RSF_CFG_FRE_BIT   = 0;
  localparam logic        RSF_CFG_RESET     = 1'b1;
  // Interrupt status bit positions and bus response codes
  localparam int          RSF_IRQ_FULL      = 0;
  localparam int          RSF_IRQ_UNF       = 1;
  localparam int          RSF_IRQ_RST       = 2;
  localparam logic [1:0]  RSF_RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RSF_RESP_SLVERR   = 2'b10;
endpackage

// ---- hw/rsf_axil_slave.sv ----
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/1ps
module rsf_axil_slave
  import rsf_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_err,
  output logic [7:0]       rd_addr,
  output logic             rd_en,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_err
);
  logic aw_have_q, aw_have_d, w_have_q, w_have_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rdat_q, rdat_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic aw_rdy_q, aw_rdy_d, w_rdy_q, w_rdy_d, ar_rdy_q, ar_rdy_d;

  assign s_awready = aw_rdy_q;
  assign s_wready  = w_rdy_q;
  assign s_arready = ar_rdy_q;
  assign s_bvalid  = bv_q;
  assign s_bresp   = br_q;
  assign s_rvalid  = rv_q;
  assign s_rresp   = rr_q;
  assign s_rdata   = rdat_q;
  assign wr_en     = ce && aw_have_q && w_have_q && !bv_q;
  assign wr_addr   = awa_q;
  assign wr_data   = wd_q;
  assign wr_strb   = ws_q;
  assign rd_addr   = s_araddr;
  assign rd_en     = ce && s_arvalid && ar_rdy_q;

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    bv_d      = bv_q;
    rv_d      = rv_q;
    awa_d     = awa_q;
    wd_d      = wd_q;
    ws_d      = ws_q;
    br_d      = br_q;
    rr_d      = rr_q;
    rdat_d    = rdat_q;
    if (s_awvalid && s_awready) begin
      aw_have_d = 1'b1;
      awa_d     = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_have_d = 1'b1;
      wd_d     = s_wdata;
      ws_d     = s_wstrb;
    end
    if (wr_en) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bv_d      = 1'b1;
      br_d      = wr_err ? RSF_RESP_SLVERR : RSF_RESP_OKAY;
    end
    if (bv_q && s_bready) begin
      bv_d = 1'b0;
    end
    if (rd_en) begin
      rv_d   = 1'b1;
      rdat_d = rd_data;
      rr_d   = rd_err ? RSF_RESP_SLVERR : RSF_RESP_OKAY;
    end else if (rv_q && s_rready) begin
      rv_d = 1'b0;
    end
    // Ready flags are registered so every bus output leaves a flop
    aw_rdy_d = !aw_have_d && !bv_d;
    w_rdy_d  = !w_have_d && !bv_d;
    ar_rdy_d = !rv_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bv_q      <= 1'b0;
      rv_q      <= 1'b0;
      awa_q     <= 8'h00;
      wd_q      <= 32'h0000_0000;
      ws_q      <= 4'h0;
      br_q      <= 2'b00;
      rr_q      <= 2'b00;
      rdat_q    <= 32'h0000_0000;
      aw_rdy_q  <= 1'b0;
      w_rdy_q   <= 1'b0;
      ar_rdy_q  <= 1'b0;
    end else if (ce) begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      bv_q      <= bv_d;
      rv_q      <= rv_d;
      awa_q     <= awa_d;
      wd_q      <= wd_d;
      ws_q      <= ws_d;
      br_q      <= br_d;
      rr_q      <= rr_d;
      rdat_q    <= rdat_d;
      aw_rdy_q  <= aw_rdy_d;
      w_rdy_q   <= w_rdy_d;
      ar_rdy_q  <= ar_rdy_d;
    end
  end
endmodule // rsf_axil_slave

// ---- hw/rsf_return_stack.sv ----
// Return address stack, fast shadow save, pc holding and table registers
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rsf_return_stack
  import rsf_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                ce,
  input  wire logic                por,
  input  wire logic [7:0]          s_awaddr,
  input  wire logic                s_awvalid,
  output logic                     s_awready,
  input  wire logic [31:0]         s_wdata,
  input  wire logic [3:0]          s_wstrb,
  input  wire logic                s_wvalid,
  output logic                     s_wready,
  output logic [1:0]               s_bresp,
  output logic                     s_bvalid,
  input  wire logic                s_bready,
  input  wire logic [7:0]          s_araddr,
  input  wire logic                s_arvalid,
  output logic                     s_arready,
  output logic [31:0]              s_rdata,
  output logic [1:0]               s_rresp,
  output logic                     s_rvalid,
  input  wire logic                s_rready,
  input  wire logic                push,
  input  wire logic                pop,
  input  wire logic                irq_vector,
  input  wire logic                fast,
  input  wire logic                computed_jump,
  input  wire logic [RSF_PC_W-1:0] pc_in,
  input  wire logic [7:0]          status_in,
  input  wire logic [7:0]          working_in,
  input  wire logic [7:0]          bank_in,
  input  wire logic [7:0]          table_rd_data,
  input  wire logic                table_rd_valid,
  output logic [RSF_PC_W-1:0]      pc_out,
  output logic                     pc_load,
  output logic                     restore,
  output logic [7:0]               status_out,
  output logic [7:0]               working_out,
  output logic [7:0]               bank_out,
  output logic                     device_reset,
  output logic                     irq
);
  logic [RSF_PC_W-1:0] stack_mem [1:RSF_DEPTH];
  logic [4:0]  sp_q, sp_d;
  logic        full_q, full_d, unf_q, unf_d, fre_q, fre_d;
  logic [7:0]  hold_h_q, hold_h_d;
  logic [4:0]  hold_u_q, hold_u_d;
  logic [RSF_PC_W-1:0] table_byte_pointer_q, table_byte_pointer_d, pc_q, pc_d;
  logic [7:0]  tbldat_q, tbldat_d;
  logic [7:0]  sh_st_q, sh_st_d, sh_w_q, sh_w_d, sh_b_q, sh_b_d;
  logic [2:0]  ist_q, ist_d, ien_q, ien_d;
  logic        pcl_q, rst_q, rst_d, irq_d, rest_d;
  logic        wr_en, rd_en, wr_err, rd_err, do_push, do_pop;
  logic [7:0]  wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0]  wr_strb;
  logic [7:0]  ptr_reg;
  logic        ptr_wr, full_ev, unf_ev, mem_we;
  logic [7:0]  pcl_sum;

  rsf_axil_slave u_bus (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_strb   (wr_strb),
    .wr_err    (wr_err),
    .rd_addr   (rd_addr),
    .rd_en     (rd_en),
    .rd_data   (rd_data),
    .rd_err    (rd_err)
  );

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a[1:0] == 2'b00) && (a <= RSF_ADDR_CORE);
  endfunction

  assign ptr_reg = {full_q, unf_q, 1'b0, sp_q};
  assign ptr_wr  = wr_en && (wr_addr == RSF_ADDR_PTR) && wr_strb[0];
  assign wr_err  = !known_addr(wr_addr);
  assign rd_err  = !known_addr(rd_addr);
  // Pushes and pops are ignored while a fault reset is being signalled
  assign do_push = (push || irq_vector) && !rst_q;
  assign do_pop  = pop && !rst_q;
  assign full_ev = do_push && (sp_q >= RSF_SP_MAX - 5'h01);
  assign unf_ev  = do_pop && (sp_q == RSF_SP_ZERO);
  assign mem_we  = do_push && (sp_q != RSF_SP_MAX);
  assign pcl_sum = pc_in[7:0] + working_in;
  assign pc_out  = pc_q;
  assign pc_load = pcl_q;
  assign device_reset = rst_q;
  assign status_out   = sh_st_q;
  assign working_out  = sh_w_q;
  assign bank_out     = sh_b_q;

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      RSF_ADDR_PTR:    rd_data = {24'h000000, ptr_reg};
      RSF_ADDR_CFG:    rd_data = {31'h0, fre_q};
      RSF_ADDR_HOLD:   rd_data = {19'h0, hold_u_q, hold_h_q};
      RSF_ADDR_TABLE_BYTE_POINTER: rd_data = {11'h0, table_byte_pointer_q};
      RSF_ADDR_TBLDAT: rd_data = {24'h000000, tbldat_q};
      RSF_ADDR_IRQ_ST: rd_data = {29'h0, ist_q};
      RSF_ADDR_IRQ_EN: rd_data = {29'h0, ien_q};
      RSF_ADDR_PC:     rd_data = {11'h0, pc_q};
      RSF_ADDR_CORE:   rd_data = 32'h0000_0000;
      default:         rd_data = 32'h0000_0000;
    endcase
  end

  always_comb begin
    sp_d     = sp_q;
    full_d   = full_q;
    unf_d    = unf_q;
    fre_d    = fre_q;
    hold_h_d = hold_h_q;
    hold_u_d = hold_u_q;
    table_byte_pointer_d = table_byte_pointer_q;
    tbldat_d = tbldat_q;
    ien_d    = ien_q;
    ist_d    = ist_q;
    rst_d    = 1'b0;
    pc_d     = pc_q;
    // Software clears first so a same-cycle event still sets the flag
    if (ptr_wr) begin
      sp_d = wr_data[4:0];
      if (!wr_data[RSF_FULL_BIT]) full_d = 1'b0;
      if (!wr_data[RSF_UNF_BIT]) unf_d = 1'b0;
    end
    if (wr_en && wr_strb[0]) begin
      unique case (wr_addr)
        RSF_ADDR_CFG:    fre_d = wr_data[RSF_CFG_FRE_BIT];
        RSF_ADDR_HOLD:   hold_h_d = wr_data[7:0];
        RSF_ADDR_TABLE_BYTE_POINTER: table_byte_pointer_d = wr_data[RSF_PC_W-1:0];
        RSF_ADDR_IRQ_EN: ien_d = wr_data[2:0];
        RSF_ADDR_IRQ_CLR: ist_d = ist_q & ~wr_data[2:0];
        default: ;
      endcase
    end
    if (wr_en && wr_strb[1] && wr_addr == RSF_ADDR_HOLD) hold_u_d = wr_data[12:8];
    if (table_rd_valid) tbldat_d = table_rd_data;
    if (do_push) begin
      pc_d = pc_in;
      if (sp_q != RSF_SP_MAX) sp_d = sp_q + 5'h01;
    end else if (do_pop) begin
      if (sp_q == RSF_SP_ZERO) begin
        pc_d = '0;
      end else begin
        pc_d = stack_mem[sp_q];
        sp_d = sp_q - 5'h01;
      end
    end else if (computed_jump) begin
      pc_d = {hold_u_q, hold_h_q, pcl_sum[7:1], 1'b0};
    end else if (wr_en && wr_strb[0] && wr_addr == RSF_ADDR_PC) begin
      pc_d = {hold_u_q, hold_h_q, wr_data[7:1], 1'b0};
    end
    if (full_ev) full_d = 1'b1;
    if (unf_ev) unf_d = 1'b1;
    if (full_ev) ist_d[RSF_IRQ_FULL] = 1'b1;
    if (unf_ev) ist_d[RSF_IRQ_UNF] = 1'b1;
    if ((full_ev || unf_ev) && fre_q) begin
      rst_d = 1'b1;
      sp_d  = RSF_SP_ZERO;
      ist_d[RSF_IRQ_RST] = 1'b1;
    end
    // Level follows the next status so the pin leaves a flop in step
    irq_d = |(ist_d & ien_d);
  end

  always_comb begin
    sh_st_d = sh_st_q;
    sh_w_d  = sh_w_q;
    sh_b_d  = sh_b_q;
    rest_d  = 1'b0;
    // Any interrupt entry outside a fault reset overwrites, whatever its priority
    if ((irq_vector || (push && fast)) && !rst_q) begin
      sh_st_d = status_in;
      sh_w_d  = working_in;
      sh_b_d  = bank_in;
    end else if (do_pop && fast) begin
      rest_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (ce && mem_we) stack_mem[sp_q + 5'h01] <= pc_in;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_q <= RSF_SP_ZERO;
      fre_q <= RSF_CFG_RESET;
      hold_h_q <= 8'h00;
      hold_u_q <= 5'h00;
      table_byte_pointer_q <= '0;
      tbldat_q <= 8'h00;
      ien_q <= 3'h0;
      ist_q <= 3'h0;
      rst_q <= 1'b0;
      pc_q <= '0;
      pcl_q <= 1'b0;
      sh_st_q <= 8'h00;
      sh_w_q <= 8'h00;
      sh_b_q <= 8'h00;
      restore <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      sp_q <= sp_d;
      fre_q <= fre_d;
      hold_h_q <= hold_h_d;
      hold_u_q <= hold_u_d;
      table_byte_pointer_q <= table_byte_pointer_d;
      tbldat_q <= tbldat_d;
      ien_q <= ien_d;
      ist_q <= ist_d;
      rst_q <= rst_d;
      pc_q <= pc_d;
      pcl_q <= (pc_d != pc_q) || do_pop || computed_jump;
      sh_st_q <= sh_st_d;
      sh_w_q <= sh_w_d;
      sh_b_q <= sh_b_d;
      restore <= rest_d;
      irq <= irq_d;
    end
  end

  // Sticky flags survive device reset; only power-on or a pointer register write with the flag bit at 0 clears them
  always_ff @(posedge aclk) begin
    if (por) begin
      full_q <= 1'b0;
      unf_q <= 1'b0;
    end else if (ce) begin
      full_q <= full_d;
      unf_q <= unf_d;
    end
  end

  a_full_sets: assert property (@(posedge aclk) disable iff (!aresetn || por)
    (ce && full_ev) |=> full_q) else $error("full flag not set");
  a_unf_sets: assert property (@(posedge aclk) disable iff (!aresetn || por)
    (ce && unf_ev) |=> unf_q && pc_q == '0) else $error("underflow not seen");
  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn || por)
    (full_q && !ptr_wr) |=> full_q) else $error("full flag dropped");
  a_fault_reset: assert property (@(posedge aclk) disable iff (!aresetn || por)
    (ce && (full_ev || unf_ev) && fre_q) |=> device_reset && sp_q == 5'h00)
    else $error("no fault reset");
  a_no_reset: assert property (@(posedge aclk) disable iff (!aresetn || por)
    (ce && !fre_q) |=> !device_reset) else $error("reset while disabled");
  a_shadow_cap: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && irq_vector && !rst_q) |=> sh_w_q == $past(working_in))
    else $error("shadow not captured");
  a_fast_ret: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && do_pop && fast && !irq_vector && !push) |=> restore)
    else $error("no restore");
  a_plain_ret: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && pop && !fast) |=> !restore) else $error("plain return restored");
  a_saturate: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !fre_q && push && sp_q == 5'h1f) |=> sp_q == 5'h1f)
    else $error("pointer passed 31");
endmodule // rsf_return_stack

// ---- tb/rsf_core_model.sv ----
// Core sequencer model: holds status, working, bank and pc, issues stack requests
`timescale 1ns/1ps
module rsf_core_model
  import rsf_pkg::*;
(
  input  wire logic                aclk,
  output logic                     push,
  output logic                     pop,
  output logic                     irq_vector,
  output logic                     fast,
  output logic                     computed_jump,
  output logic                     table_rd_valid,
  output logic [7:0]               table_rd_data,
  output logic [RSF_PC_W-1:0]      pc_in,
  output logic [7:0]               status_in,
  output logic [7:0]               working_in,
  output logic [7:0]               bank_in,
  input  wire logic [RSF_PC_W-1:0] pc_out,
  input  wire logic                pc_load,
  input  wire logic                restore,
  input  wire logic [7:0]          status_out,
  input  wire logic [7:0]          working_out,
  input  wire logic [7:0]          bank_out
);
  logic [7:0]          st_q, wk_q, bk_q;
  logic [RSF_PC_W-1:0] pc_q;
  assign status_in  = st_q;
  assign working_in = wk_q;
  assign bank_in    = bk_q;
  assign pc_in      = pc_q;
  initial begin
    {push, pop, irq_vector, fast, computed_jump, table_rd_valid} = '0;
    {st_q, wk_q, bk_q, table_rd_data} = '0;
    pc_q = '0;
  end
  // The core takes restored registers and a new pc when the block says so
  always @(posedge aclk) begin
    if (restore === 1'b1) begin
      st_q <= status_out;
      wk_q <= working_out;
      bk_q <= bank_out;
    end
    if (pc_load === 1'b1) pc_q <= pc_out;
  end
  task automatic set(input logic [7:0] s, w, b, input logic [RSF_PC_W-1:0] p);
    @(posedge aclk);
    // A pending load from the block would race these updates
    while (pc_load === 1'b1 || restore === 1'b1) @(posedge aclk);
    st_q <= s;
    wk_q <= {w[7:1], 1'b0}; // Offsets stay even
    bk_q <= b;
    pc_q <= p;
  endtask
  // k = {push, pop, irq_vector, computed_jump, table_rd_valid}, one cycle
  task automatic op(input logic [4:0] k, input logic f, input logic [7:0] d);
    @(posedge aclk);
    {push, pop, irq_vector, computed_jump, table_rd_valid} <= k;
    fast <= f;
    table_rd_data <= d;
    @(posedge aclk);
    {push, pop, irq_vector, computed_jump, table_rd_valid} <= '0;
    fast <= 1'b0;
  endtask
endmodule // rsf_core_model

// ---- tb/rsf_return_stack_tb.sv ----
// Testbench of the return stack block with a core model on its far side
`timescale 1ns/1ps
module rsf_return_stack_tb
  import rsf_pkg::*;
;
  localparam logic [4:0] k_push = 5'h10, k_pop = 5'h08, k_vec = 5'h04, k_jmp = 5'h02;
  logic aclk, aresetn, ce, por, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, pc_load, restore;
  logic device_reset, irq, push, pop, irq_vector, fast, computed_jump, table_rd_valid;
  logic [7:0]          s_awaddr, s_araddr, table_rd_data, status_in, working_in, bank_in;
  logic [7:0]          status_out, working_out, bank_out;
  logic [31:0]         s_wdata, s_rdata;
  logic [3:0]          s_wstrb;
  logic [1:0]          s_bresp, s_rresp;
  logic [RSF_PC_W-1:0] pc_in, pc_out;
  int err_count = 0, n_compared = 0, n_rst = 0;

  rsf_return_stack i_rsf_return_stack (.aclk, .aresetn, .ce, .por, .s_awaddr, .s_awvalid,
    .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .push, .pop,
    .irq_vector, .fast, .computed_jump, .pc_in, .status_in, .working_in, .bank_in,
    .table_rd_data, .table_rd_valid, .pc_out, .pc_load, .restore, .status_out, .working_out,
    .bank_out, .device_reset, .irq);
  rsf_core_model i_rsf_core_model (.aclk, .push, .pop, .irq_vector, .fast, .computed_jump,
    .table_rd_valid, .table_rd_data, .pc_in, .status_in, .working_in, .bank_in, .pc_out,
    .pc_load, .restore, .status_out, .working_out, .bank_out);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) if (device_reset === 1'b1) n_rst <= n_rst + 1;

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw, w, ta, tw;
    @(posedge aclk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    {aw, w} = 2'b00;
    while (!(aw && w)) begin
      @(negedge aclk);
      ta = s_awready && s_awvalid;
      tw = s_wready && s_wvalid;
      @(posedge aclk);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
      aw = aw | ta;
      w = w | tw;
    end
    do @(negedge aclk); while (s_bvalid !== 1'b1);
    chk("bresp", {30'h0, s_bresp}, {30'h0, er});
    @(posedge aclk);
    s_bready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(negedge aclk); while (s_arready !== 1'b1);
    @(posedge aclk);
    s_arvalid <= 1'b0;
    do @(negedge aclk); while (s_rvalid !== 1'b1);
    chk("rdata", s_rdata, e);
    chk("rresp", {30'h0, s_rresp}, {30'h0, er});
    @(posedge aclk);
    s_rready <= 1'b0;
  endtask
  // Let a core request land, then look at the core model's registers
  task automatic settle();
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic regs(input logic [7:0] s, w, b, input logic [RSF_PC_W-1:0] p);
    chk("status", status_in, s);
    chk("working", working_in, w);
    chk("bank", bank_in, b);
    chk("pc", pc_in, p);
  endtask

  task automatic t_regs();
    rdc(RSF_ADDR_PTR, 32'h0, RSF_RESP_OKAY);
    rdc(RSF_ADDR_CFG, 32'h1, RSF_RESP_OKAY);
    wr(RSF_ADDR_PTR, 32'hff, RSF_RESP_OKAY);
    rdc(RSF_ADDR_PTR, 32'h1f, RSF_RESP_OKAY);
    wr(RSF_ADDR_PTR, 32'h0, RSF_RESP_OKAY);
    rdc(RSF_ADDR_CORE, 32'h0, RSF_RESP_OKAY);
    rdc(8'h30, 32'h0, RSF_RESP_SLVERR);
    wr(8'h30, 32'h0, RSF_RESP_SLVERR);
  endtask
  task automatic t_fast();
    i_rsf_core_model.set(8'h11, 8'h22, 8'h33, 21'h000100);
    i_rsf_core_model.op(k_push, 1'b1, 8'h0);
    i_rsf_core_model.set(8'h44, 8'h56, 8'h66, 21'h000500);
    i_rsf_core_model.op(k_pop, 1'b1, 8'h0);
    settle();
    regs(8'h11, 8'h22, 8'h33, 21'h000100);
  endtask
  task automatic t_irq();
    i_rsf_core_model.set(8'h01, 8'h02, 8'h03, 21'h000200);
    i_rsf_core_model.op(k_vec, 1'b0, 8'h0);
    i_rsf_core_model.set(8'h04, 8'h06, 8'h08, 21'h000300);
    i_rsf_core_model.op(k_vec, 1'b0, 8'h0);
    i_rsf_core_model.set(8'h07, 8'h0a, 8'h09, 21'h000400);
    i_rsf_core_model.op(k_pop, 1'b0, 8'h0);
    settle();
    regs(8'h07, 8'h0a, 8'h09, 21'h000300);
    i_rsf_core_model.op(k_pop, 1'b1, 8'h0);
    settle();
    regs(8'h04, 8'h06, 8'h08, 21'h000200);
  endtask
  task automatic t_unf();
    wr(RSF_ADDR_IRQ_EN, 32'h2, RSF_RESP_OKAY);
    i_rsf_core_model.set(8'h0, 8'h0, 8'h0, 21'h000077);
    i_rsf_core_model.op(k_pop, 1'b0, 8'h0);
    settle();
    chk("pc", pc_in, 21'h0);
    chk("fault_reset", n_rst, 1);
    chk("irq", irq, 1'b1);
    rdc(RSF_ADDR_PTR, 32'h40, RSF_RESP_OKAY);
    rdc(RSF_ADDR_IRQ_ST, 32'h6, RSF_RESP_OKAY);
    wr(RSF_ADDR_IRQ_CLR, 32'h6, RSF_RESP_OKAY);
    chk("irq", irq, 1'b0);
    wr(RSF_ADDR_PTR, 32'h40, RSF_RESP_OKAY);
    rdc(RSF_ADDR_PTR, 32'h40, RSF_RESP_OKAY);
    wr(RSF_ADDR_PTR, 32'h0, RSF_RESP_OKAY);
    rdc(RSF_ADDR_PTR, 32'h0, RSF_RESP_OKAY);
    i_rsf_core_model.op(k_pop, 1'b0, 8'h0);
    @(posedge aclk);
    por <= 1'b1;
    @(posedge aclk);
    por <= 1'b0;
    rdc(RSF_ADDR_PTR, 32'h0, RSF_RESP_OKAY);
  endtask
  task automatic t_full();
    wr(RSF_ADDR_CFG, 32'h0, RSF_RESP_OKAY);
    wr(RSF_ADDR_IRQ_CLR, 32'h7, RSF_RESP_OKAY);
    n_rst = 0;
    for (int i = 1; i <= 30; i++) begin
      i_rsf_core_model.set(8'h0, 8'h0, 8'h0, 21'(i * 4));
      i_rsf_core_model.op(k_push, 1'b0, 8'h0);
    end
    rdc(RSF_ADDR_PTR, 32'h1e, RSF_RESP_OKAY);
    for (int i = 31; i <= 33; i++) begin
      i_rsf_core_model.set(8'h0, 8'h0, 8'h0, 21'(i * 4));
      i_rsf_core_model.op(k_push, 1'b0, 8'h0);
      rdc(RSF_ADDR_PTR, 32'h9f, RSF_RESP_OKAY);
    end
    rdc(RSF_ADDR_IRQ_ST, 32'h1, RSF_RESP_OKAY);
    i_rsf_core_model.op(k_pop, 1'b0, 8'h0);
    settle();
    chk("pc", pc_in, 21'd124);
    chk("fault_reset", n_rst, 0);
    wr(RSF_ADDR_PTR, 32'h0, RSF_RESP_OKAY);
  endtask
  task automatic t_jump();
    wr(RSF_ADDR_HOLD, 32'h1234, RSF_RESP_OKAY);
    i_rsf_core_model.set(8'h0, 8'h06, 8'h0, 21'h000050);
    i_rsf_core_model.op(k_jmp, 1'b0, 8'h0);
    settle();
    chk("pc", pc_in, 21'h123456);
    wr(RSF_ADDR_HOLD, 32'h0a55, RSF_RESP_OKAY);
    wr(RSF_ADDR_PC, 32'h80, RSF_RESP_OKAY);
    settle();
    chk("pc", pc_in, 21'h0a5580);
    i_rsf_core_model.op(5'h01, 1'b0, 8'ha5);
    rdc(RSF_ADDR_TBLDAT, 32'ha5, RSF_RESP_OKAY);
    wr(RSF_ADDR_TABLE_BYTE_POINTER, 32'h123, RSF_RESP_OKAY);
    rdc(RSF_ADDR_TABLE_BYTE_POINTER, 32'h123, RSF_RESP_OKAY);
    // A push while the clock enable is low must leave the pointer alone
    @(posedge aclk);
    ce <= 1'b0;
    i_rsf_core_model.op(k_push, 1'b0, 8'h0);
    ce <= 1'b1;
    rdc(RSF_ADDR_PTR, 32'h0, RSF_RESP_OKAY);
  endtask

  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    // Power-on reset clears the sticky flags along with the bus reset
    por = 1'b1;
    ce = 1'b1;
    s_awaddr = '0;
    s_araddr = '0;
    s_wdata = '0;
    s_wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    por <= 1'b0;
    t_regs();
    t_fast();
    t_irq();
    t_unf();
    t_full();
    t_jump();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    end_sim();
  end
endmodule // rsf_return_stack_tb
